// ### mcag_cfg.svh
// Purpose: Offsets, field positions, reset values for the modulo address gen
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef MCAG_CFG_SVH
`define MCAG_CFG_SVH

`define MCAG_OFS_CONTROL      8'h00
`define MCAG_OFS_X_START      8'h04
`define MCAG_OFS_X_END        8'h08
`define MCAG_OFS_Y_START      8'h0C
`define MCAG_OFS_Y_END        8'h10
`define MCAG_OFS_STATUS       8'h14

`define MCAG_XSEL_LSB         0
`define MCAG_YSEL_LSB         4
`define MCAG_YEN_BIT          14
`define MCAG_XEN_BIT          15
`define MCAG_SEL_OFF          4'hF

`define MCAG_RST_CONTROL      16'h00FF
`define MCAG_RST_BOUND        16'h0000

`define MCAG_ST_XFAULT_BIT    0
`define MCAG_ST_YFAULT_BIT    1
`define MCAG_ST_WRAP_LSB      4

`define MCAG_CHANNELS         3

`endif

// ### mcag_pkg.sv
// Purpose: Types shared by the modulo address generator and its users
// Assumes: 16-bit data addresses, 16 working registers
// Notes:   Channel 0 X read, 1 X write, 2 Y
package mcag_pkg;

   typedef logic [15:0] mcag_addr_t;
   typedef logic [3:0]  mcag_wreg_t;

   // One address update offered by a core address generator
   typedef struct packed {
      logic       valid;
      mcag_wreg_t wreg;
      mcag_addr_t ptr;
      mcag_addr_t step;
   } mcag_req_t;

   // Updated pointer returned one cycle later
   typedef struct packed {
      logic       valid;
      mcag_addr_t addr;
      logic       wrapped;
   } mcag_rsp_t;

   typedef struct packed {
      logic       active;
      logic       wordOnly;
      mcag_wreg_t sel;
      mcag_addr_t startBound;
      mcag_addr_t endBound;
   } mcag_chan_cfg_t;

   typedef enum logic [1:0]
   {
      MCAG_APB_IDLE   = 2'b00,
      MCAG_APB_ACCESS = 2'b01
   } mcag_apb_state_t;

endpackage

// ### mcag_modulo_gen.sv
// Purpose: Hardware circular-buffer addressing for X and Y address generators
// Assumes: Single clock mclk, synchronous active-high reset, APB slave
// Notes:   Each update answers one cycle after the request
`include "mcag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module mcag_modulo_gen
   import mcag_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output var  logic        pready,
   output var  logic [31:0] prdata,
   output var  logic        pslverr,
   // Address generator requests, channel 0 X read, 1 X write, 2 Y
   input  wire mcag_req_t   agReq [`MCAG_CHANNELS],
   // Updated pointers
   output var  mcag_rsp_t   agRsp [`MCAG_CHANNELS]
);

   // Register file
   logic [15:0]     moduloBitrevControl;
   logic [15:0]     xBufferStartBound;
   logic [15:0]     xBufferEndBound;
   logic [15:0]     yBufferStartBound;
   logic [15:0]     yBufferEndBound;
   logic [2:0]      wrapSeen;
   logic [15:0]     next_moduloBitrevControl;
   logic [15:0]     next_xBufferStartBound;
   logic [15:0]     next_xBufferEndBound;
   logic [15:0]     next_yBufferStartBound;
   logic [15:0]     next_yBufferEndBound;
   logic [2:0]      next_wrapSeen;
   mcag_apb_state_t apbState;
   mcag_apb_state_t next_apbState;
   logic            next_pready;
   logic [31:0]     next_prdata;
   logic            next_pslverr;

   // Derived configuration
   logic [3:0]      xPointerSelect;
   logic [3:0]      yPointerSelect;
   logic            xCircularEnable;
   logic            yCircularEnable;
   logic            xFault;
   logic            yFault;
   logic [15:0]     statusWord;
   logic            writeHit;
   logic            lowLane;
   logic            highLane;
   logic            mapped;
   logic [2:0]      wrapEvent;
   mcag_chan_cfg_t  chanCfg [`MCAG_CHANNELS];

   assign xPointerSelect  = moduloBitrevControl[`MCAG_XSEL_LSB +: 4];
   assign yPointerSelect  = moduloBitrevControl[`MCAG_YSEL_LSB +: 4];
   assign xCircularEnable = moduloBitrevControl[`MCAG_XEN_BIT];
   assign yCircularEnable = moduloBitrevControl[`MCAG_YEN_BIT];

   // Length is implied by the bound difference; inverted bounds are unusable,
   // and 16-bit bounds cannot describe more than 64 Kbytes
   assign xFault = xBufferEndBound < xBufferStartBound;
   assign yFault = yBufferEndBound < yBufferStartBound;

   assign statusWord = {9'h000, wrapSeen, 2'h0, yFault, xFault};

   always_comb
   begin
      chanCfg[0].active     = xCircularEnable && !xFault &&
                              (xPointerSelect != `MCAG_SEL_OFF);
      chanCfg[0].wordOnly   = 1'b0;
      chanCfg[0].sel        = xPointerSelect;
      chanCfg[0].startBound = xBufferStartBound;
      chanCfg[0].endBound   = xBufferEndBound;
      chanCfg[1]            = chanCfg[0];
      chanCfg[2].active     = yCircularEnable && !yFault &&
                              (yPointerSelect != `MCAG_SEL_OFF);
      chanCfg[2].wordOnly   = 1'b1;
      chanCfg[2].sel        = yPointerSelect;
      chanCfg[2].startBound = yBufferStartBound;
      chanCfg[2].endBound   = yBufferEndBound;
   end

   // Pointer update per channel
   genvar ch;
   generate
      for (ch = 0; ch < `MCAG_CHANNELS; ch = ch + 1)
      begin : gChan
         logic [16:0] sum;
         logic [16:0] endNext;
         logic        stepDown;
         logic        over;
         logic        under;
         logic        hit;
         logic [15:0] wrapped;
         logic [15:0] modAddr;
         mcag_rsp_t   next_rsp;

         assign stepDown = agReq[ch].step[15];
         assign sum      = {1'b0, agReq[ch].ptr} +
                           {agReq[ch].step[15], agReq[ch].step};
         assign endNext  = {1'b0, chanCfg[ch].endBound} + 17'h00001;
         // Selected register only; others step linearly
         assign hit      = chanCfg[ch].active &&
                           (agReq[ch].wreg == chanCfg[ch].sel);
         // Both bounds are checked, so power-of-two buffers work both ways
         assign over     = !stepDown &&
                           (sum > {1'b0, chanCfg[ch].endBound});
         assign under    = stepDown &&
                           (sum[16] ||
                            (sum[15:0] < chanCfg[ch].startBound));

         always_comb
         begin
            wrapped = sum[15:0];
            if (over)
            begin
               wrapped = 16'(chanCfg[ch].startBound + sum[15:0] -
                             endNext[15:0]);
            end
            else if (under)
            begin
               wrapped = 16'(endNext[15:0] -
                             (chanCfg[ch].startBound - sum[15:0]));
            end
            modAddr = hit ? wrapped : sum[15:0];
            if (hit && chanCfg[ch].wordOnly)
            begin
               modAddr[0] = 1'b0;
            end
            next_rsp.valid   = agReq[ch].valid;
            next_rsp.addr    = agReq[ch].valid ? modAddr : agRsp[ch].addr;
            next_rsp.wrapped = agReq[ch].valid && hit && (over || under);
         end

         assign wrapEvent[ch] = next_rsp.wrapped;

         always_ff @(posedge mclk)
         begin
            if (sys_rst)
            begin
               agRsp[ch] <= '0;
            end
            else
            begin
               agRsp[ch] <= next_rsp;
            end
         end
      end
   endgenerate

   // APB decode
   assign mapped   = (paddr == `MCAG_OFS_CONTROL) ||
                     (paddr == `MCAG_OFS_X_START) ||
                     (paddr == `MCAG_OFS_X_END)   ||
                     (paddr == `MCAG_OFS_Y_START) ||
                     (paddr == `MCAG_OFS_Y_END)   ||
                     (paddr == `MCAG_OFS_STATUS);
   assign writeHit = psel && penable && pready && pwrite && mapped;
   assign lowLane  = pstrb[0];
   assign highLane = pstrb[1];

   function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                             input logic [15:0] data,
                                             input logic        lo,
                                             input logic        hi);
      logic [15:0] res;
      res = old;
      if (lo)
      begin
         res[7:0] = data[7:0];
      end
      if (hi)
      begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   always_comb
   begin
      next_moduloBitrevControl = moduloBitrevControl;
      next_xBufferStartBound   = xBufferStartBound;
      next_xBufferEndBound     = xBufferEndBound;
      next_yBufferStartBound   = yBufferStartBound;
      next_yBufferEndBound     = yBufferEndBound;
      next_wrapSeen            = wrapSeen;
      if (writeHit)
      begin
         case (paddr)
            `MCAG_OFS_CONTROL:
               next_moduloBitrevControl = laneMerge(moduloBitrevControl,
                  pwdata[15:0], lowLane, highLane);
            `MCAG_OFS_X_START:
               next_xBufferStartBound = laneMerge(xBufferStartBound,
                  pwdata[15:0], lowLane, highLane);
            `MCAG_OFS_X_END:
               next_xBufferEndBound = laneMerge(xBufferEndBound,
                  pwdata[15:0], lowLane, highLane);
            `MCAG_OFS_Y_START:
               next_yBufferStartBound = laneMerge(yBufferStartBound,
                  pwdata[15:0], lowLane, highLane);
            `MCAG_OFS_Y_END:
               next_yBufferEndBound = laneMerge(yBufferEndBound,
                  pwdata[15:0], lowLane, highLane);
            `MCAG_OFS_STATUS:
               if (lowLane)
               begin
                  next_wrapSeen = wrapSeen &
                     ~pwdata[`MCAG_ST_WRAP_LSB +: 3];
               end
            default:
               next_wrapSeen = wrapSeen;
         endcase
      end
      // A wrap in the clearing cycle survives the clear
      next_wrapSeen = next_wrapSeen | wrapEvent;
   end

   // Ready one cycle after setup, so every access takes two cycles
   always_comb
   begin
      next_apbState = apbState;
      next_pready   = 1'b0;
      next_prdata   = prdata;
      next_pslverr  = 1'b0;
      case (apbState)
         MCAG_APB_IDLE:
            if (psel && !penable)
            begin
               next_apbState = MCAG_APB_ACCESS;
               next_pready   = 1'b1;
               next_pslverr  = !mapped;
               if (!pwrite)
               begin
                  case (paddr)
                     `MCAG_OFS_CONTROL:
                        next_prdata = {16'h0000, moduloBitrevControl};
                     `MCAG_OFS_X_START:
                        next_prdata = {16'h0000, xBufferStartBound};
                     `MCAG_OFS_X_END:
                        next_prdata = {16'h0000, xBufferEndBound};
                     `MCAG_OFS_Y_START:
                        next_prdata = {16'h0000, yBufferStartBound};
                     `MCAG_OFS_Y_END:
                        next_prdata = {16'h0000, yBufferEndBound};
                     `MCAG_OFS_STATUS:
                        next_prdata = {16'h0000, statusWord};
                     default:
                        next_prdata = 32'h00000000;
                  endcase
               end
            end
         MCAG_APB_ACCESS:
            next_apbState = MCAG_APB_IDLE;
         default:
            next_apbState = MCAG_APB_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         moduloBitrevControl <= `MCAG_RST_CONTROL;
         xBufferStartBound   <= `MCAG_RST_BOUND;
         xBufferEndBound     <= `MCAG_RST_BOUND;
         yBufferStartBound   <= `MCAG_RST_BOUND;
         yBufferEndBound     <= `MCAG_RST_BOUND;
         wrapSeen            <= 3'h0;
         apbState            <= MCAG_APB_IDLE;
         pready              <= 1'b0;
         prdata              <= 32'h00000000;
         pslverr             <= 1'b0;
      end
      else
      begin
         moduloBitrevControl <= next_moduloBitrevControl;
         xBufferStartBound   <= next_xBufferStartBound;
         xBufferEndBound     <= next_xBufferEndBound;
         yBufferStartBound   <= next_yBufferStartBound;
         yBufferEndBound     <= next_yBufferEndBound;
         wrapSeen            <= next_wrapSeen;
         apbState            <= next_apbState;
         pready              <= next_pready;
         prdata              <= next_prdata;
         pslverr             <= next_pslverr;
      end
   end

endmodule

`default_nettype wire

// ### mcag_modulo_chk.sv
// Purpose: Port properties of the modulo address generator
// Assumes: Control is shadowed from APB writes
// Notes:   Bound to mcag_modulo_gen
`include "mcag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module mcag_modulo_chk
   import mcag_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Address generators
   input wire mcag_req_t   agReq [`MCAG_CHANNELS],
   input wire mcag_rsp_t   agRsp [`MCAG_CHANNELS]
);
   logic [15:0] ctl;
   logic [15:0] next_ctl;
   logic        xOn;
   logic        yOn;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   always_comb
   begin
      next_ctl = ctl;
      if (psel && penable && pready && pwrite && paddr == 8'h00)
         next_ctl = {pstrb[1] ? pwdata[15:8] : ctl[15:8],
                     pstrb[0] ? pwdata[7:0] : ctl[7:0]};
   end
   always_ff @(posedge mclk)
      ctl <= sys_rst ? 16'h00FF : next_ctl;
   // Only the selected register of an enabled space is corrected
   assign xOn = ctl[15] && ctl[3:0] != 4'hF && agReq[0].wreg == ctl[3:0];
   assign yOn = ctl[14] && ctl[7:4] != 4'hF && agReq[2].wreg == ctl[7:4];
   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   unmapped_err_a: assert property (
      psel && !penable && paddr > 8'h14 |=> pready && pslverr)
      else $error("unmapped access accepted");
   rsp_timing_a: assert property (agReq[0].valid |=> agRsp[0].valid)
      else $error("update not answered");
   rsp_quiet_a: assert property (
      !agReq[1].valid |=> !agRsp[1].valid && !agRsp[1].wrapped)
      else $error("answer without request");
   x_linear_a: assert property (
      agReq[0].valid && !xOn |=> !agRsp[0].wrapped &&
      agRsp[0].addr == $past(agReq[0].ptr) + $past(agReq[0].step))
      else $error("X update corrected while inactive");
   y_linear_a: assert property (
      agReq[2].valid && !yOn |=> !agRsp[2].wrapped &&
      agRsp[2].addr == $past(agReq[2].ptr) + $past(agReq[2].step))
      else $error("Y update corrected while inactive");
   y_word_a: assert property (
      agReq[2].valid && yOn |=> !agRsp[2].addr[0])
      else $error("Y result odd");
   high_zero_a: assert property (prdata[31:16] == 16'h0000)
      else $error("read data upper half set");
endmodule
bind mcag_modulo_gen mcag_modulo_chk chk_u (.mclk(mclk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .agReq(agReq), .agRsp(agRsp));
`default_nettype wire

// ### mcag_agu_model.sv
// Purpose: Core address generator stand-in issuing pointer updates
// Assumes: One request per call; channel -1 gives an idle cycle
// Notes:   Idle ptr and step are scrambled (wreg stays 0) so stale values are never trusted
`include "mcag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module mcag_agu_model
   import mcag_pkg::*;
(
   // Clock
   input  wire logic      mclk,
   // Requests
   output var  mcag_req_t agReq [`MCAG_CHANNELS]
);
   initial
   begin
      for (int i = 0; i < `MCAG_CHANNELS; i++)
         agReq[i] = '0;
   end
   task automatic issue(input int ch, input mcag_wreg_t w,
                        input mcag_addr_t p, input mcag_addr_t s);
      @(posedge mclk);
      for (int i = 0; i < `MCAG_CHANNELS; i++)
         agReq[i] <= (i == ch) ? {1'b1, w, p, s} : {1'b0, 36'($urandom)};
   endtask
endmodule
`default_nettype wire

// ### mcag_testbench.sv
// Purpose: Self-checking bench for the modulo address generator
// Assumes: pstrb on the two low lanes, except one high-lane-only write
// Notes:   Power-of-two buffers, so updates run in both directions
`include "mcag_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench import mcag_pkg::*;;
   logic        mclk;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h3;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   mcag_req_t   agReq [`MCAG_CHANNELS];
   mcag_rsp_t   agRsp [`MCAG_CHANNELS];
   logic [32:0] apbQ [$];
   logic [18:0] rspQ [$];
   logic [15:0] ctl;
   logic [15:0] bnd [4];
   logic [2:0]  seenWrap = 3'h0;
   logic [31:0] rstTab [6] = '{32'h00FF, 0, 0, 0, 0, 0};
   logic [15:0] ctlTab [5] = '{16'hC053, 16'hC0FF, 16'h0053, 16'h8053,
                               16'h4053};
   int          error_cnt = 0;
   int          checked = 0;
   int          cyc = 0;
   mcag_modulo_gen dut_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .agReq(agReq), .agRsp(agRsp));
   mcag_agu_model agu_u (.mclk(mclk), .agReq(agReq));
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      apbQ.push_back(e);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // No limit here; only the bench timeout ends a wait that pready never ends
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wrap reference; Y space is index 1 of the bound pairs
   function automatic logic [16:0] modRef(int ch, mcag_wreg_t w,
                                          mcag_addr_t p, mcag_addr_t s);
      int          y;
      logic [15:0] st;
      logic [15:0] en;
      logic [15:0] sum;
      logic        wr;
      y = ch / 2;
      st = bnd[2 * y];
      en = bnd[2 * y + 1];
      sum = p + s;
      wr = 1'b0;
      if (ctl[15 - y] && ctl[4 * y +: 4] != 4'hF && w == ctl[4 * y +: 4])
      begin
         wr = (!s[15] && sum > en) || (s[15] && sum < st);
         sum = !wr ? sum : s[15] ? en + 16'h1 - (st - sum)
                                 : st + sum - en - 16'h1;
         sum[0] = sum[0] & (y == 0);
      end
      return {sum, wr};
   endfunction
   always @(posedge mclk)
   begin
      if (psel && penable && pready === 1'b1)
         chk({pslverr, pwrite ? 32'h0 : prdata}, apbQ.pop_front());
      for (int c = 0; c < `MCAG_CHANNELS; c++)
         if (agRsp[c].valid === 1'b1)
            chk({c[1:0], agRsp[c].addr, agRsp[c].wrapped},
                rspQ.pop_front());
   end
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         test_done();
      end
   end
   initial
   begin
      int          ch;
      mcag_wreg_t  w;
      mcag_wreg_t  sl;
      mcag_addr_t  p;
      mcag_addr_t  s;
      logic [16:0] e;
      ch = $urandom(26093);
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      foreach (rstTab[k])
         apb(1'b0, 8'(4 * k), 32'h0, {1'b0, rstTab[k]});
      apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
      bnd = '{16'h1000, 16'h101F, 16'h2000, 16'h203F};
      foreach (bnd[k])
         apb(1'b1, 8'(4 * k + 4), {16'h0, bnd[k]}, 33'h0);
      foreach (ctlTab[k])
      begin
         ctl = ctlTab[k];
         apb(1'b1, 8'h00, {16'h0, ctl}, 33'h0);
         apb(1'b0, 8'h00, 32'h0, {17'h0, ctl});
         repeat (40)
         begin
            ch = $urandom_range(0, 2);
            sl = ctl[4 * (ch / 2) +: 4];
            // Frame and stack pointers are never used as modulo pointer
            w = ($urandom_range(0, 1) && sl != 4'hF) ? sl
                : 4'($urandom_range(0, 13));
            p = bnd[ch / 2 * 2]
                + 16'($urandom_range(0, 16'h40) % (bnd[ch / 2 * 2 + 1]
                - bnd[ch / 2 * 2] + 1));
            s = 16'($urandom_range(0, 8)) - 16'h4;
            e = modRef(ch, w, p, s);
            seenWrap[ch] = seenWrap[ch] | e[0];
            rspQ.push_back({2'(ch), e});
            agu_u.issue(ch, w, p, s);
         end
         agu_u.issue(-1, 4'h0, 16'h0, 16'h0);
      end
      apb(1'b0, 8'h14, 32'h0, {26'h0, seenWrap, 4'h0});
      apb(1'b1, 8'h14, 32'h70, 33'h0);
      apb(1'b0, 8'h14, 32'h0, 33'h0);
      apb(1'b1, 8'h18, 32'hFFFF, {1'b1, 32'h0});
      // High lane only: X end drops below X start and must be flagged
      pstrb <= 4'h2;
      apb(1'b1, 8'h08, 32'h0F00, 33'h0);
      pstrb <= 4'h3;
      apb(1'b0, 8'h08, 32'h0, {17'h0, 16'h0F1F});
      apb(1'b0, 8'h14, 32'h0, {1'b0, 32'h1});
      repeat (2) @(posedge mclk);
      chk(36'(rspQ.size()), 36'h0);
      test_done();
   end
endmodule
`default_nettype wire
